//--- dual_capture_compare_unit.sv
// module: two-set capture/compare unit with its register port, edge synchroniser and flag register
// assumes: reference timer count comes from logic on sys_clk_i; edge pin is asynchronous
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module dual_capture_compare_unit #(
	parameter int TIMER_W = 16
) (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [15:0] reference_timer_count_i,
	input  wire logic        edge_input_pin_i,
	input  wire logic        adc_enable_i,
	output logic      [1:0]  compare_output_pin_o,
	output logic      [1:0]  compare_output_owned_o,
	output logic      [1:0]  set_request_flag_o,
	output logic             conversion_start_o
);

	// ********************************************************************
	// elaboration check
	// ********************************************************************
	// capture registers and byte access are built for a 16-bit timer only
	if (TIMER_W != ccu_pkg::TIMER_W) begin : bad_timer_width
		$error("TIMER_W must be 16");
	end

	// ********************************************************************
	// edge pin synchroniser and edge detect
	// ********************************************************************
	logic edge_meta;
	logic edge_sync;
	logic edge_prev;
	logic rise;
	logic next_rise;
	logic fall;
	logic next_fall;

	// the pin level is taken as is, so a port write driving it can capture
	always_comb begin
		next_rise = edge_sync && !edge_prev;
		next_fall = !edge_sync && edge_prev;
	end

	// edge_meta feeds edge_sync only; detect looks at the second and third stages
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			edge_meta <= 1'b0;
			edge_sync <= 1'b0;
			edge_prev <= 1'b0;
			rise      <= 1'b0;
			fall      <= 1'b0;
		end else begin
			edge_meta <= edge_input_pin_i;
			edge_sync <= edge_meta;
			edge_prev <= edge_sync;
			rise      <= next_rise;
			fall      <= next_fall;
		end
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	logic [7:0]  mode_ctrl;
	logic [7:0]  next_mode_ctrl;
	logic [1:0]  flag;
	logic [1:0]  next_flag;
	logic [7:0]  rdata;
	logic [7:0]  next_rdata;
	logic [15:0] set_value [2];
	logic [1:0]  set_event;
	logic [1:0]  set_out;
	logic [1:0]  set_owned;
	logic [1:0]  set_trigger;
	logic        wr_mode;
	logic        wr_flag;
	logic [1:0]  wr_lo;
	logic [1:0]  wr_hi;

	// write decode, one strobe per register
	always_comb begin
		wr_mode  = reg_wr_i && (reg_addr_i == ccu_pkg::MODE_CTRL_ADDR);
		wr_flag  = reg_wr_i && (reg_addr_i == ccu_pkg::FLAG_REG_ADDR);
		wr_lo[0] = reg_wr_i && (reg_addr_i == ccu_pkg::SET1_LO_ADDR);
		wr_hi[0] = reg_wr_i && (reg_addr_i == ccu_pkg::SET1_HI_ADDR);
		wr_lo[1] = reg_wr_i && (reg_addr_i == ccu_pkg::SET2_LO_ADDR);
		wr_hi[1] = reg_wr_i && (reg_addr_i == ccu_pkg::SET2_HI_ADDR);
	end

	// flags: a write loads them, a hardware event in the same cycle still wins
	always_comb begin
		next_mode_ctrl = wr_mode ? reg_wdata_i : mode_ctrl;
		next_flag      = flag;
		if (wr_flag) begin
			next_flag = {reg_wdata_i[ccu_pkg::SET2_FLAG_BIT], reg_wdata_i[ccu_pkg::SET1_FLAG_BIT]};
		end
		next_flag = next_flag | set_event;
	end

	// read mux; data stand only in the cycle after the strobe, unmapped reads give zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ccu_pkg::MODE_CTRL_ADDR: next_rdata = mode_ctrl;
				// bit 0 belongs to the timer's rollover flag; this unit never drives it
				ccu_pkg::FLAG_REG_ADDR: begin
					next_rdata = 8'h00;
					next_rdata[ccu_pkg::SET1_FLAG_BIT] = flag[0];
					next_rdata[ccu_pkg::SET2_FLAG_BIT] = flag[1];
				end
				ccu_pkg::SET1_LO_ADDR:   next_rdata = set_value[0][7:0];
				ccu_pkg::SET1_HI_ADDR:   next_rdata = set_value[0][15:8];
				ccu_pkg::SET2_LO_ADDR:   next_rdata = set_value[1][7:0];
				ccu_pkg::SET2_HI_ADDR:   next_rdata = set_value[1][15:8];
				default:                 next_rdata = 8'h00;
			endcase
		end
	end

	// register bank, cleared by any device reset
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode_ctrl <= ccu_pkg::MODE_CTRL_RST;
			flag      <= ccu_pkg::FLAG_RST;
			rdata     <= 8'h00;
		end else begin
			mode_ctrl <= next_mode_ctrl;
			flag      <= next_flag;
			rdata     <= next_rdata;
		end
	end

	// ********************************************************************
	// the two register sets
	// ********************************************************************
	for (genvar g = 0; g < 2; g++) begin : set_gen
		cc_set_if port_if ();

		assign port_if.mode   = mode_ctrl[g * ccu_pkg::SET2_MODE_LSB +: ccu_pkg::MODE_W];
		assign port_if.timer  = reference_timer_count_i;
		assign port_if.rise   = rise;
		assign port_if.fall   = fall;
		assign port_if.wdata  = reg_wdata_i;
		assign port_if.wr_lo  = wr_lo[g];
		assign port_if.wr_hi  = wr_hi[g];
		assign port_if.adc_en = adc_enable_i;
		assign set_value[g]   = port_if.value;
		assign set_event[g]   = port_if.event_pulse;
		assign set_out[g]     = port_if.out_level;
		assign set_owned[g]   = port_if.out_owned;
		assign set_trigger[g] = port_if.trigger;

		cc_register_set set_inst (
			.sys_clk_i (sys_clk_i),
			.sys_rst_i (sys_rst_i),
			.port_if   (port_if.unit)
		);
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	// the trigger only starts a conversion; no timer reset or rollover path exists
	assign conversion_start_o     = |set_trigger;
	assign compare_output_pin_o   = set_out;
	assign compare_output_owned_o = set_owned;
	assign set_request_flag_o     = flag;
	assign reg_rdata_o            = rdata;

	// ********************************************************************
	// checks
	// ********************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// a synchronised edge needs three more edges to reach its flag:
	// rise or fall pulse, then capture and event, then the flag itself
	sequence synced_rise_s;
		$rose(edge_sync) && !wr_mode && !wr_flag;
	endsequence
	sequence synced_fall_s;
		$fell(edge_sync) && !wr_mode && !wr_flag;
	endsequence
	sequence flag_one_up_s;
		##3 flag[0];
	endsequence
	sequence flag_two_up_s;
		##3 flag[1];
	endsequence

	rise_to_flag_a: assert property (synced_rise_s and mode_ctrl[3:0] == ccu_pkg::MODE_RISE
		|-> flag_one_up_s)
		else $error("rising edge capture did not raise flag of set 1");
	fall_to_flag_a: assert property (synced_fall_s and mode_ctrl[7:4] == ccu_pkg::MODE_FALL
		|-> flag_two_up_s)
		else $error("falling edge capture did not raise flag of set 2");

	// the edge pulses trail the synchronised level by one edge
	edge_detect_a: assert property ($rose(edge_prev) |-> rise)
		else $error("edge detect missed a synchronised rise");
	fall_detect_a: assert property ($fell(edge_prev) |-> fall)
		else $error("edge detect missed a synchronised fall");
	// the first stage may be metastable, so only the second one may move on
	sync_chain_a: assert property (edge_sync == $past(edge_meta))
		else $error("synchroniser skipped a stage");
	// set 2 sees the same pulse as set 1 and latches the same timer word
	capture_value_a: assert property (rise && mode_ctrl[7:4] == ccu_pkg::MODE_RISE
		|=> set_value[1] == $past(reference_timer_count_i))
		else $error("set 2 did not capture the timer");
	// an off set must stay silent, whatever the pin and the timer do
	off_quiet_a: assert property (mode_ctrl[7:6] == ccu_pkg::GROUP_OFF
		|=> !set_event[1])
		else $error("set 2 raised an event while off");

	// ********************************************************************
	// checks: request flags
	// ********************************************************************
	// an event lands in its own flag bit at the next edge
	flag_set_a: assert property (set_event[1] |=> flag[1])
		else $error("set 2 event lost its flag");
	flag_one_set_a: assert property (set_event[0] |=> flag[0])
		else $error("set 1 event lost its flag");

	// software is the only party that may lower a flag
	flag_hold_a: assert property (flag[0] && !wr_flag |=> flag[0])
		else $error("flag cleared without a software write");
	flag_hold_two_a: assert property (flag[1] && !wr_flag |=> flag[1])
		else $error("flag of set 2 cleared without a software write");
	flag_clear_a: assert property (wr_flag && !reg_wdata_i[ccu_pkg::SET1_FLAG_BIT] && !set_event[0]
		|=> !flag[0])
		else $error("software write of zero did not clear flag");

	// every compare mode but the reserved one flags its match, the trigger mode included
	special_flag_a: assert property (conversion_start_o |=> |flag)
		else $error("special event raised no flag");
	// the converter may be off; then the match only flags
	conv_gate_a: assert property (conversion_start_o |-> $past(adc_enable_i))
		else $error("conversion started with the converter disabled");
	swint_owned_a: assert property (mode_ctrl[3:2] == ccu_pkg::GROUP_SWI
		|-> !compare_output_owned_o[0])
		else $error("software interrupt mode claimed pin 1");
	// only set, clear and toggle on match may hand the pin to the latch
	owned_mode_a: assert property (compare_output_owned_o[0]
		|-> mode_ctrl[3:2] == 2'h2 && mode_ctrl[3:0] != ccu_pkg::MODE_RSV)
		else $error("pin 1 owned outside the output compare modes");

	// ********************************************************************
	// checks: register port
	// ********************************************************************
	// writes take effect at the edge that sees the strobe
	mode_write_a: assert property (wr_mode |=> mode_ctrl == $past(reg_wdata_i))
		else $error("mode write did not land");
	// a capture in the same cycle owns the register, so only quiet cycles are checked
	value_write_a: assert property (wr_lo[0] && !rise && !fall
		|=> set_value[0][7:0] == $past(reg_wdata_i))
		else $error("set 1 low byte write did not land");

	// read data stand in the cycle after the strobe and then fall back to zero
	read_mode_a: assert property (reg_rd_i && reg_addr_i == ccu_pkg::MODE_CTRL_ADDR
		|=> reg_rdata_o == $past(mode_ctrl) ##1 reg_rdata_o == 8'h00 || $past(reg_rd_i))
		else $error("mode register read back wrong");
	// the byte lanes of a held value come back unchanged
	value_read_a: assert property (reg_rd_i && reg_addr_i == ccu_pkg::SET1_HI_ADDR
		|=> reg_rdata_o == $past(set_value[0][15:8]))
		else $error("set 1 high byte read back wrong");
	flag_read_a: assert property (reg_rd_i && reg_addr_i == ccu_pkg::FLAG_REG_ADDR
		|=> reg_rdata_o == {4'h0, $past(flag), 2'h0})
		else $error("flag register read back wrong");
	// bit 0 belongs to the timer, so this unit must never answer with it set
	rollover_free_a: assert property (reg_rd_i && reg_addr_i == ccu_pkg::FLAG_REG_ADDR
		|=> !reg_rdata_o[ccu_pkg::ROLLOVER_FLAG_BIT])
		else $error("rollover flag driven by this unit");
	// unmapped places answer zero so software can probe them safely
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i > ccu_pkg::SET2_HI_ADDR
		|=> reg_rdata_o == 8'h00)
		else $error("unmapped address read not zero");
	// a stale byte left on the port could be mistaken for a new answer
	idle_read_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outlived their cycle");

endmodule // dual_capture_compare_unit

`default_nettype wire

//--- ccu_pkg.sv
// package: register map, field positions, mode codes and reset values of the dual capture/compare unit
// assumes: an 8-bit register port with 3-bit addresses and a 16-bit reference timer in the same clock domain
package ccu_pkg;

	// ********************************************************************
	// register offsets
	// ********************************************************************
	localparam logic [2:0] MODE_CTRL_ADDR = 3'h0;
	localparam logic [2:0] FLAG_REG_ADDR  = 3'h1;
	localparam logic [2:0] SET1_LO_ADDR   = 3'h2;
	localparam logic [2:0] SET1_HI_ADDR   = 3'h3;
	localparam logic [2:0] SET2_LO_ADDR   = 3'h4;
	localparam logic [2:0] SET2_HI_ADDR   = 3'h5;

	// ********************************************************************
	// field positions and widths
	// ********************************************************************
	localparam int MODE_W           = 4;
	localparam int SET1_MODE_LSB    = 0;
	localparam int SET2_MODE_LSB    = 4;
	localparam int ROLLOVER_FLAG_BIT = 0;
	localparam int SET1_FLAG_BIT    = 2;
	localparam int SET2_FLAG_BIT    = 3;
	localparam int TIMER_W          = 16;
	localparam int DATA_W           = 8;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [7:0]  MODE_CTRL_RST = 8'h00;
	localparam logic [1:0]  FLAG_RST      = 2'h0;
	localparam logic [15:0] VALUE_RST     = 16'h0000;
	localparam logic [3:0]  PRESC_RST     = 4'h0;

	// ********************************************************************
	// per-set mode codes
	// ********************************************************************
	localparam logic [1:0] GROUP_OFF  = 2'h0;
	localparam logic [1:0] GROUP_CAPT = 2'h1;
	localparam logic [1:0] GROUP_SWI  = 2'h3;
	localparam logic [3:0] MODE_FALL  = 4'h4;
	localparam logic [3:0] MODE_RISE  = 4'h5;
	localparam logic [3:0] MODE_RISE4 = 4'h6;
	localparam logic [3:0] MODE_RISE16 = 4'h7;
	localparam logic [3:0] MODE_SET   = 4'h8;
	localparam logic [3:0] MODE_CLR   = 4'h9;
	localparam logic [3:0] MODE_TGL   = 4'ha;
	localparam logic [3:0] MODE_RSV   = 4'hb;
	localparam logic [3:0] MODE_SPEC  = 4'hf;
	localparam logic [3:0] PRESC4_LAST  = 4'h3;
	localparam logic [3:0] PRESC16_LAST = 4'hf;

endpackage

//--- cc_set_if.sv
// interface: the signals between the unit's register front end and one capture/compare set
// assumes: both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none

interface cc_set_if;
	logic [3:0]  mode;
	logic [15:0] timer;
	logic        rise;
	logic        fall;
	logic [7:0]  wdata;
	logic        wr_lo;
	logic        wr_hi;
	logic        adc_en;
	logic [15:0] value;
	logic        event_pulse;
	logic        out_level;
	logic        out_owned;
	logic        trigger;

	// the set itself
	modport unit (input mode, timer, rise, fall, wdata, wr_lo, wr_hi, adc_en,
		output value, event_pulse, out_level, out_owned, trigger);
	// the register front end
	modport ctrl (output mode, timer, rise, fall, wdata, wr_lo, wr_hi, adc_en,
		input value, event_pulse, out_level, out_owned, trigger);
endinterface

`default_nettype wire

//--- cc_register_set.sv
// module: one capture/compare register set with its edge prescaler and compare output latch
// assumes: edges arrive already synchronised as one-cycle pulses; timer is on this clock
`timescale 1ns/10ps
`default_nettype none

module cc_register_set (
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	cc_set_if.unit    port_if
);

	// ********************************************************************
	// mode decode
	// ********************************************************************
	logic        off;
	logic        capt;
	logic        capture_hit;
	logic        match_hit;
	logic [15:0] value;
	logic [15:0] next_value;
	logic [3:0]  presc;
	logic [3:0]  next_presc;
	logic        out_latch;
	logic        next_out_latch;
	logic [3:0]  prev_mode;
	logic        match_last;
	logic        next_match_last;
	logic        event_pulse;
	logic        next_event_pulse;
	logic        trigger;
	logic        next_trigger;

	// the capture event per edge selection; prescale counts rising edges only
	always_comb begin
		off         = (port_if.mode[3:2] == ccu_pkg::GROUP_OFF);
		capt        = (port_if.mode[3:2] == ccu_pkg::GROUP_CAPT);
		capture_hit = 1'b0;
		case (port_if.mode)
			ccu_pkg::MODE_FALL:   capture_hit = port_if.fall;
			ccu_pkg::MODE_RISE:   capture_hit = port_if.rise;
			ccu_pkg::MODE_RISE4:  capture_hit = port_if.rise && (presc[1:0] == ccu_pkg::PRESC4_LAST[1:0]);
			ccu_pkg::MODE_RISE16: capture_hit = port_if.rise && (presc == ccu_pkg::PRESC16_LAST);
			default:              capture_hit = 1'b0;
		endcase
		// fire once per equality, the timer may sit on one value for many clocks
		next_match_last = port_if.mode[3] && (port_if.timer == value);
		match_hit       = next_match_last && !match_last;
	end

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		next_value = value;
		if (capture_hit) begin
			next_value = port_if.timer;
		end else if (port_if.wr_lo) begin
			next_value = {value[15:8], port_if.wdata};
		end else if (port_if.wr_hi) begin
			next_value = {port_if.wdata, value[7:0]};
		end
		// a switch between prescale settings keeps the count
		next_presc = presc;
		if (!capt) begin
			next_presc = ccu_pkg::PRESC_RST;
		end else if (port_if.rise) begin
			next_presc = presc + 4'h1;
		end
		next_out_latch = out_latch;
		if (off) begin
			next_out_latch = 1'b0;
		end else if (prev_mode[3:2] == ccu_pkg::GROUP_OFF && port_if.mode == ccu_pkg::MODE_CLR) begin
			next_out_latch = 1'b1;
		end else if (match_hit) begin
			case (port_if.mode)
				ccu_pkg::MODE_SET: next_out_latch = 1'b1;
				ccu_pkg::MODE_CLR: next_out_latch = 1'b0;
				ccu_pkg::MODE_TGL: next_out_latch = !out_latch;
				default:           next_out_latch = out_latch;
			endcase
		end
		next_event_pulse = capture_hit || (match_hit && port_if.mode != ccu_pkg::MODE_RSV);
		next_trigger     = match_hit && (port_if.mode == ccu_pkg::MODE_SPEC) && port_if.adc_en;
	end

	// registers, all cleared by the device reset
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			value       <= ccu_pkg::VALUE_RST;
			presc       <= ccu_pkg::PRESC_RST;
			out_latch   <= 1'b0;
			prev_mode   <= 4'h0;
			match_last  <= 1'b0;
			event_pulse <= 1'b0;
			trigger     <= 1'b0;
		end else begin
			value       <= next_value;
			presc       <= next_presc;
			out_latch   <= next_out_latch;
			prev_mode   <= port_if.mode;
			match_last  <= next_match_last;
			event_pulse <= next_event_pulse;
			trigger     <= next_trigger;
		end
	end

	assign port_if.value       = value;
	assign port_if.event_pulse = event_pulse;
	assign port_if.out_level   = out_latch;
	assign port_if.trigger     = trigger;
	// the pin belongs to the set only in the three output-driving compare modes
	assign port_if.out_owned   = (port_if.mode == ccu_pkg::MODE_SET) || (port_if.mode == ccu_pkg::MODE_CLR)
		|| (port_if.mode == ccu_pkg::MODE_TGL);

	// ********************************************************************
	// checks
	// ********************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	capture_load_a: assert property (capture_hit |=> value == $past(port_if.timer))
		else $error("capture did not latch the timer");
	presc_clear_a: assert property (!capt |=> presc == 4'h0)
		else $error("prescaler not cleared outside capture");
	compare_set_a: assert property (match_hit && port_if.mode == ccu_pkg::MODE_SET |=> out_latch)
		else $error("set on match failed");
	compare_toggle_a: assert property (match_hit && port_if.mode == ccu_pkg::MODE_TGL && !off
		|=> out_latch != $past(out_latch))
		else $error("toggle on match failed");
	off_default_a: assert property (off |=> !out_latch)
		else $error("output latch not at default while off");
	swint_pin_a: assert property (port_if.mode[3:2] == ccu_pkg::GROUP_SWI && $past(port_if.mode[3:2])
		== ccu_pkg::GROUP_SWI |-> $stable(out_latch) && !port_if.out_owned)
		else $error("software interrupt mode touched the pin");
	trigger_gate_a: assert property (trigger |-> $past(port_if.mode) == ccu_pkg::MODE_SPEC && event_pulse)
		else $error("trigger without special event match");
	capture_event_a: assert property (capture_hit |=> event_pulse)
		else $error("capture raised no event");

endmodule // cc_register_set

`default_nettype wire

//--- ccu_pin_model.sv
// model of the pins around the unit: the edge input driver and the two compare pins
// assumes: the bench moves the edge pin through set_level, by non-blocking assignment
`timescale 1ns/10ps
`default_nettype none

module ccu_pin_model (
	input  wire logic [1:0] latch_i,
	input  wire logic [1:0] owned_i,
	output logic            edge_pin_o,
	output logic      [1:0] cmp_pin_o
);
	// the edge pin may be driven by the port itself, the unit sees only the level
	initial edge_pin_o = 1'b0;

	task automatic set_level(input logic v);
		edge_pin_o <= v;
	endtask

	// a compare pin that the unit does not own floats high through its pull-up
	assign cmp_pin_o = (owned_i & latch_i) | ~owned_i;
endmodule // ccu_pin_model

`default_nettype wire

//--- dual_capture_compare_unit_tb.sv
// self-checking bench: register port, capture of every event kind, six of the eight compare modes
// assumes: one 100 MHz clock; the bench plays register master and reference timer
`timescale 1ns/10ps
`default_nettype none

module dual_capture_compare_unit_tb;
	logic        clk         = 1'b0;
	logic        rst         = 1'b1;
	logic [2:0]  addr        = 3'h0;
	logic [7:0]  wdata       = 8'h00;
	logic        wr          = 1'b0;
	logic        rd          = 1'b0;
	logic [15:0] tmr         = 16'h0000;
	logic        adc_en      = 1'b0;
	logic [7:0]  rdata, d;
	logic [1:0]  latch, owned, flag, cmp_pin;
	logic        pin, conv, el;
	logic [15:0] last_r, last_f, got, v;
	int          error_cnt   = 0;
	int          check_count = 0;
	int          conv_n      = 0;
	logic [3:0]  cap_m [4]   = '{ccu_pkg::MODE_FALL, ccu_pkg::MODE_RISE, ccu_pkg::MODE_RISE4, ccu_pkg::MODE_RISE16};
	int          cap_n [4]   = '{1, 2, 4, 16};
	logic [3:0]  cmp_m [6]   = '{ccu_pkg::MODE_SET, ccu_pkg::MODE_CLR, ccu_pkg::MODE_TGL, ccu_pkg::MODE_RSV,
		4'hc, ccu_pkg::MODE_SPEC};

	always #5 clk = ~clk;

	dual_capture_compare_unit i_dual_capture_compare_unit (.sys_clk_i(clk), .sys_rst_i(rst),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.reference_timer_count_i(tmr), .edge_input_pin_i(pin), .adc_enable_i(adc_en),
		.compare_output_pin_o(latch), .compare_output_owned_o(owned), .set_request_flag_o(flag),
		.conversion_start_o(conv));
	ccu_pin_model i_ccu_pin_model (.latch_i(latch), .owned_i(owned), .edge_pin_o(pin), .cmp_pin_o(cmp_pin));

	// conversion starts are one-cycle pulses, so they are counted as they come
	always @(posedge clk) begin
		if (conv === 1'b1) conv_n++;
	end

	// ********************************************************************
	// shared tasks and expectations
	// ********************************************************************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD at %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] dv);
		@(posedge clk);
		addr <= a;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] dv);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 dv = rdata;
	endtask

	task automatic rd16(input logic [2:0] a, output logic [15:0] r);
		logic [7:0] lo, hi;
		rd_reg(a, lo);
		rd_reg(a + 3'h1, hi);
		r = {hi, lo};
	endtask

	// each phase holds five cycles, long enough for the timer to be sampled with it
	task automatic pulse(input int n);
		repeat (n) begin
			last_r = 16'($urandom);
			last_f = 16'($urandom);
			@(posedge clk);
			tmr <= last_r;
			i_ccu_pin_model.set_level(1'b1);
			repeat (5) @(posedge clk);
			tmr <= last_f;
			i_ccu_pin_model.set_level(1'b0);
			repeat (4) @(posedge clk);
		end
	endtask

	function automatic logic exp_latch(input logic [3:0] m, input int k);
		if (m == ccu_pkg::MODE_SET) return 1'b1;
		if (m == ccu_pkg::MODE_TGL) return k == 0;
		return 1'b0;
	endfunction

	function automatic logic exp_own(input logic [3:0] m);
		return m == ccu_pkg::MODE_SET || m == ccu_pkg::MODE_CLR || m == ccu_pkg::MODE_TGL;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// a hang costs a mismatch; the whole run needs well under this span
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end

	// ********************************************************************
	// main sequence
	// ********************************************************************
	initial begin
		void'($urandom(32'h5439ccbd));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped places read zero and swallow writes
		rd_reg(ccu_pkg::MODE_CTRL_ADDR, d);
		chk(16'(d), 16'h0000);
		wr_reg(3'h7, 8'h5a);
		rd_reg(3'h6, d);
		chk(16'(d), 16'h0000);
		rd_reg(ccu_pkg::MODE_CTRL_ADDR, d);
		chk(16'(d), 16'h0000);
		$display("register test done");
		// capture on both sets; prescaled kinds stay quiet until their last edge
		for (int i = 0; i < 4; i++) begin
			wr_reg(ccu_pkg::MODE_CTRL_ADDR, 8'h00);
			wr_reg(ccu_pkg::MODE_CTRL_ADDR, {cap_m[i], cap_m[i]});
			wr_reg(ccu_pkg::FLAG_REG_ADDR, 8'h00);
			// the clear lands at this very edge, so look once it has settled
			#1 chk(16'(flag), 16'h0000);
			if (cap_n[i] > 2) begin
				pulse(cap_n[i] - 1);
				chk(16'(flag), 16'h0000);
			end
			pulse((cap_n[i] > 2) ? 1 : cap_n[i]);
			repeat (12) @(posedge clk);
			chk(16'(flag), 16'h0003);
			rd16(ccu_pkg::SET1_LO_ADDR, got);
			chk(got, (i == 0) ? last_f : last_r);
			rd16(ccu_pkg::SET2_LO_ADDR, got);
			chk(got, (i == 0) ? last_f : last_r);
			$display("capture test %0d done", i);
		end
		// compare on set 1 only; set 2 stays off and must not move
		for (int i = 0; i < 6; i++) begin
			v = 16'($urandom);
			wr_reg(ccu_pkg::MODE_CTRL_ADDR, 8'h00);
			// the latch follows the mode one edge after the write
			@(posedge clk);
			#1 chk(16'(latch), 16'h0000);
			wr_reg(ccu_pkg::SET1_LO_ADDR, v[7:0]);
			wr_reg(ccu_pkg::SET1_HI_ADDR, v[15:8]);
			tmr <= ~v;
			adc_en <= 1'($urandom);
			wr_reg(ccu_pkg::MODE_CTRL_ADDR, {4'h0, cmp_m[i]});
			wr_reg(ccu_pkg::FLAG_REG_ADDR, 8'h00);
			conv_n = 0;
			chk(16'({owned, latch}), 16'({1'b0, exp_own(cmp_m[i]), 1'b0, cmp_m[i] == ccu_pkg::MODE_CLR}));
			// two matches, the timer leaving the value in between
			for (int k = 0; k < 2; k++) begin
				@(posedge clk);
				tmr <= v;
				@(posedge clk);
				tmr <= ~v;
				repeat (3) @(posedge clk);
				el = exp_latch(cmp_m[i], k);
				chk(16'(latch), 16'(el));
				chk(16'(cmp_pin), 16'({1'b1, exp_own(cmp_m[i]) ? el : 1'b1}));
			end
			rd_reg(ccu_pkg::FLAG_REG_ADDR, d);
			chk(16'(d), (cmp_m[i] == ccu_pkg::MODE_RSV) ? 16'h0000 : 16'h0004);
			chk(16'(conv_n), (cmp_m[i] == ccu_pkg::MODE_SPEC && adc_en) ? 16'h0002 : 16'h0000);
			$display("compare test %0d done", i);
		end
		tally_and_finish();
	end
endmodule // dual_capture_compare_unit_tb

`default_nettype wire
